// ==== bench/cdt_threshold_unit_tb.sv ====
/*
  Self-checking bench for the card detection threshold unit: APB register
  traffic, detection runs against the borders, suppress, timeout, interrupts.
  Assumes a short SAMPLE_LIMIT so that timed-out runs stay brief.
*/
`timescale 1ns/1ps
`default_nettype none

module cdt_threshold_unit_tb;
  import cdt_pkg::*;

  localparam int unsigned SL = 8;

  logic              sys_clk;
  logic              rstn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [3:0]        pstrb;
  logic              pready;
  logic [31:0]       prdata;
  logic              pslverr;
  logic [31:0]       oldRdata;
  logic              oldSlverr;
  logic              runStart;
  logic              runDone;
  logic [5:0]        measI;
  logic [5:0]        measQ;
  logic              iChanging;
  logic              qChanging;
  logic              sampleActive;
  logic              fullDriveSelect;
  logic              noiseFilterEnable;
  logic              detectInterruptFlag;
  logic              irq;
  logic [5:0]        iup;
  logic [5:0]        qlo;
  logic [5:0]        qup;
  logic [5:0]        ilo;
  logic [3:0]        opt;
  logic [2:0]        en;
  logic [15:0]       seed;
  logic [32:0]       expq[$];
  int                failures;
  int                samplesChecked;
  int                pulses;
  int                activeCnt;

  cdt_threshold_unit #(.NEWER_VARIANT(1'b1), .SAMPLE_LIMIT(SL)) dut_u (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .runStart(runStart), .runDone(runDone), .measI(measI),
    .measQ(measQ), .iChanging(iChanging), .qChanging(qChanging),
    .sampleActive(sampleActive), .fullDriveSelect(fullDriveSelect),
    .noiseFilterEnable(noiseFilterEnable), .detectInterruptFlag(detectInterruptFlag),
    .irq(irq));

  // older silicon shares every input; only its option register reads are judged
  cdt_threshold_unit #(.NEWER_VARIANT(1'b0), .SAMPLE_LIMIT(SL)) dut_old_u (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(), .prdata(oldRdata),
    .pslverr(oldSlverr), .runStart(runStart), .runDone(runDone), .measI(measI),
    .measQ(measQ), .iChanging(iChanging), .qChanging(qChanging), .sampleActive(),
    .fullDriveSelect(), .noiseFilterEnable(), .detectInterruptFlag(), .irq());

  always #5 sys_clk = ~sys_clk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("failures %0d comparisons %0d", failures, samplesChecked);
    if (failures == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      input logic [32:0] e);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    if (!w)
      expq.push_back(e);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      failures++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 33'h0);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic err);
    xfer(1'b0, a, 32'h0, {err, d});
  endtask

  // the upper I border is spread over the top two bits of three registers
  task automatic setb(input logic [5:0] iu, ql, qu, il);
    iup = iu;
    qlo = ql;
    qup = qu;
    ilo = il;
    wr(ADDR_Q_LOWER, {24'h0, iu[5:4], ql});
    wr(ADDR_Q_UPPER, {24'h0, iu[3:2], qu});
    wr(ADDR_I_LOWER, {24'h0, iu[1:0], il});
    rd(ADDR_Q_LOWER, {24'h0, iu[5:4], ql}, 1'b0);
    rd(ADDR_Q_UPPER, {24'h0, iu[3:2], qu}, 1'b0);
    rd(ADDR_I_LOWER, {24'h0, iu[1:0], il}, 1'b0);
  endtask

  task automatic run(input logic [5:0] i, q, input logic ic, qc, supp, useDone);
    int         pb;
    int         ab;
    logic       hit;
    logic [2:0] st;
    hit = (i > iup) || (q > qlo) || (q > qup) || (i < ilo);
    st = {!useDone, 1'b1, hit && !supp};
    pb = pulses;
    ab = activeCnt;
    @(posedge sys_clk);
    runStart <= 1'b1;
    measI <= i;
    measQ <= q;
    iChanging <= ic;
    qChanging <= qc;
    @(posedge sys_clk);
    runStart <= 1'b0;
    if (supp)
      wr(ADDR_Q_RESULT, 32'h40);
    if (useDone)
    begin
      @(posedge sys_clk);
      runDone <= 1'b1;
      @(posedge sys_clk);
      runDone <= 1'b0;
    end
    else
      repeat (SL + 4) @(posedge sys_clk);
    // junk after capture must not reach results or the decision
    seed = lfsr(seed);
    measI <= seed[5:0];
    measQ <= seed[11:6];
    iChanging <= seed[12];
    qChanging <= seed[13];
    repeat (6) @(posedge sys_clk);
    chk(33'(pulses - pb), {32'h0, hit && !supp});
    chk({32'h0, (activeCnt - ab) <= SL + 1}, 33'h1);
    if (!useDone)
      chk(33'(activeCnt - ab), 33'(SL));
    rd(ADDR_I_RESULT, {26'h0, i}, 1'b0);
    rd(ADDR_Q_RESULT, {25'h0, supp, q}, 1'b0);
    rd(ADDR_OPTIONS, {28'h0, opt[3:2], opt[2] ? {qc, ic} : 2'b00}, 1'b0);
    rd(ADDR_EVT_STAT, {29'h0, st}, 1'b0);
    chk({32'h0, irq}, {32'h0, |(st & en)});
    wr(ADDR_EVT_CLR, 32'h7);
    rd(ADDR_EVT_STAT, 32'h0, 1'b0);
    chk({32'h0, irq}, 33'h0);
  endtask

  always @(posedge sys_clk)
  begin
    if (detectInterruptFlag === 1'b1)
      pulses++;
    if (sampleActive === 1'b1)
      activeCnt++;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
    begin
      if (expq.size() == 0)
        chk({pslverr, prdata}, 33'h1ffffffff);
      else
        chk({pslverr, prdata}, expq.pop_front());
      if (paddr === ADDR_OPTIONS)
        chk({oldSlverr, oldRdata}, 33'h0);
    end
  end

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    failures++;
    summarize();
  end

  initial
  begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    {psel, penable, pwrite, runStart, runDone, iChanging, qChanging} = 7'h0;
    {paddr, pwdata, measI, measQ} = '0;
    pstrb = 4'hf;
    seed = 16'h0003;
    {failures, samplesChecked, pulses, activeCnt} = '0;
    {iup, qlo, qup, ilo, opt, en} = '0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    expq.delete();
    rd(ADDR_OPTIONS, 32'h0, 1'b0);
    rd(ADDR_Q_LOWER, 32'h0, 1'b0);
    rd(ADDR_I_RESULT, 32'h0, 1'b0);
    rd(ADDR_Q_RESULT, 32'h0, 1'b0);
    rd(ADDR_EVT_STAT, 32'h0, 1'b0);
    wr(12'hffc, 32'hff);
    rd(12'hffc, 32'h0, 1'b1);
    wr(ADDR_I_RESULT, 32'h3f);
    wr(ADDR_EVT_STAT, 32'h7);
    rd(ADDR_I_RESULT, 32'h0, 1'b0);
    rd(ADDR_EVT_STAT, 32'h0, 1'b0);
    wr(ADDR_EVT_EN, 32'h7);
    en = 3'h7;
    rd(ADDR_EVT_EN, 32'h7, 1'b0);
    wr(ADDR_OPTIONS, 32'hff);
    opt = 4'hc;
    @(negedge sys_clk);
    chk({31'h0, fullDriveSelect, noiseFilterEnable}, 33'h3);
    @(posedge sys_clk);
    pstrb <= 4'he;
    wr(ADDR_OPTIONS, 32'h0);
    pstrb <= 4'hf;
    // lane 0 off: the write above must leave both option bits set
    rd(ADDR_OPTIONS, 32'hc, 1'b0);
    wr(ADDR_OPTIONS, 32'h08);
    opt = 4'h8;
    @(negedge sys_clk);
    chk({31'h0, fullDriveSelect, noiseFilterEnable}, 33'h2);
    setb(6'h3f, 6'h3f, 6'h3f, 6'h00);
    run(6'h20, 6'h20, 1'b1, 1'b1, 1'b0, 1'b1);
    wr(ADDR_OPTIONS, 32'h04);
    opt = 4'h4;
    setb(6'h20, 6'h3f, 6'h3f, 6'h00);
    run(6'h20, 6'h20, 1'b1, 1'b0, 1'b0, 1'b1);
    run(6'h21, 6'h20, 1'b0, 1'b1, 1'b0, 1'b1);
    setb(6'h3f, 6'h10, 6'h3f, 6'h00);
    run(6'h20, 6'h10, 1'b0, 1'b0, 1'b0, 1'b1);
    run(6'h20, 6'h11, 1'b1, 1'b1, 1'b0, 1'b1);
    setb(6'h3f, 6'h3f, 6'h10, 6'h00);
    run(6'h20, 6'h10, 1'b0, 1'b0, 1'b0, 1'b1);
    run(6'h20, 6'h11, 1'b0, 1'b0, 1'b0, 1'b1);
    setb(6'h3f, 6'h3f, 6'h3f, 6'h10);
    run(6'h10, 6'h20, 1'b0, 1'b0, 1'b0, 1'b1);
    run(6'h0f, 6'h20, 1'b0, 1'b0, 1'b1, 1'b1);
    run(6'h0f, 6'h20, 1'b0, 1'b0, 1'b0, 1'b1);
    run(6'h0f, 6'h20, 1'b1, 1'b1, 1'b0, 1'b0);
    wr(ADDR_EVT_EN, 32'h0);
    en = 3'h0;
    run(6'h0f, 6'h20, 1'b0, 1'b0, 1'b0, 1'b1);
    wr(ADDR_EVT_EN, 32'h7);
    en = 3'h7;
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      setb(seed[5:0], seed[11:6], {seed[15:12], 2'b11}, seed[7:2]);
      seed = lfsr(seed);
      run(seed[5:0], seed[11:6], seed[12], seed[13], seed[14], seed[15]);
    end
    summarize();
  end
endmodule

`default_nettype wire

// ==== common/cdt_pkg.sv ====
/*
  Shared constants for the card detection threshold unit: register indices
  and byte addresses, field positions, reset values, event bits, timing and
  the sequencer state type.
  Assumes a 100 MHz system clock and an APB register bus with 32-bit data.
*/
`default_nettype none

package cdt_pkg;

  localparam int unsigned ADDR_W = 12;

  // offsets are register indices; the byte address is index * 4
  localparam logic [7:0] IDX_OPTIONS  = 8'h3a;
  localparam logic [7:0] IDX_Q_LOWER  = 8'h3f;
  localparam logic [7:0] IDX_Q_UPPER  = 8'h40;
  localparam logic [7:0] IDX_I_LOWER  = 8'h41;
  localparam logic [7:0] IDX_I_RESULT = 8'h42;
  localparam logic [7:0] IDX_Q_RESULT = 8'h43;
  localparam logic [7:0] IDX_EVT_STAT = 8'h50;
  localparam logic [7:0] IDX_EVT_EN   = 8'h51;
  localparam logic [7:0] IDX_EVT_CLR  = 8'h52;

  localparam logic [ADDR_W-1:0] ADDR_OPTIONS  = {2'h0, IDX_OPTIONS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_Q_LOWER  = {2'h0, IDX_Q_LOWER, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_Q_UPPER  = {2'h0, IDX_Q_UPPER, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_I_LOWER  = {2'h0, IDX_I_LOWER, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_I_RESULT = {2'h0, IDX_I_RESULT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_Q_RESULT = {2'h0, IDX_Q_RESULT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EVT_STAT = {2'h0, IDX_EVT_STAT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EVT_EN   = {2'h0, IDX_EVT_EN, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EVT_CLR  = {2'h0, IDX_EVT_CLR, 2'h0};

  // field positions
  localparam int unsigned BORDER_W      = 6;
  localparam int unsigned IUP_SLICE_POS = 6;
  localparam int unsigned SUPPRESS_POS  = 6;
  localparam int unsigned OPT_DRIVE_POS = 3;
  localparam int unsigned OPT_FILT_POS  = 2;
  localparam int unsigned OPT_QCHG_POS  = 1;
  localparam int unsigned OPT_ICHG_POS  = 0;

  // event bits of the status, enable and clear registers
  localparam int unsigned EVT_W        = 3;
  localparam int unsigned EVT_DETECT   = 0;
  localparam int unsigned EVT_RUN_DONE = 1;
  localparam int unsigned EVT_TIMEOUT  = 2;

  localparam logic [7:0]       BORDER_RST = 8'h00;
  localparam logic [5:0]       RESULT_RST = 6'h00;
  localparam logic [EVT_W-1:0] EVT_RST    = 3'h0;

  // longest sampling time, rounded down to whole cycles
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned SAMPLE_MAX_NS  = 4720;
  localparam int unsigned SAMPLE_MAX_CYC = SAMPLE_MAX_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_EVAL   = 3'b100
  } cdt_state_type;

endpackage

`default_nettype wire

// ==== logic/cdt_threshold_unit.sv ====
/*
  Card detection threshold unit: border registers, result registers, option
  register, run sequencer with sampling bound, border decision and the event
  interrupt registers, all behind an APB slave.
  Assumes the measurement front end runs on sys_clk and drives runStart,
  runDone, the channel values and the change flags synchronously.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - upper I border built from three registers
// - slices 5:4, 3:2, 1:0 from q_low, q_up, i_low
// - I above upper border raises detect request
// - Q above lower Q border raises request
// - Q above upper Q border raises request
// - I below lower I border raises request
// - last I result readable, bits 7:6 zero
// - last Q result readable, bit 7 zero
// - suppress bit blocks requests until next run
// - options register only on newer variant
// - option bit 3 selects full drive level
// - filter option; sampling bounded to 4.72 us
// - Q change flag, only with filter
// - I change flag, only with filter
module cdt_threshold_unit
  import cdt_pkg::*;
#(
  parameter bit          NEWER_VARIANT = 1'b1,
  parameter int unsigned SAMPLE_LIMIT  = SAMPLE_MAX_CYC
)(
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              runStart,
  input  wire logic              runDone,
  input  wire logic [5:0]        measI,
  input  wire logic [5:0]        measQ,
  input  wire logic              iChanging,
  input  wire logic              qChanging,
  output logic                   sampleActive,
  output logic                   fullDriveSelect,
  output logic                   noiseFilterEnable,
  output logic                   detectInterruptFlag,
  output logic                   irq
);

  localparam int SmpBound = int'(SAMPLE_LIMIT) + 1;

  cdt_state_type state_q;
  cdt_state_type state_d;

  logic [7:0]       qLowerReg_q;
  logic [7:0]       qUpperReg_q;
  logic [7:0]       iLowerReg_q;
  logic [5:0]       iResult_q;
  logic [5:0]       qResult_q;
  logic             suppress_q;
  logic             optDrive_q;
  logic             optFilter_q;
  logic             iChg_q;
  logic             qChg_q;
  logic [8:0]       sampleCnt_q;
  logic             detectReq_q;
  logic [EVT_W-1:0] evtStat_q;
  logic [EVT_W-1:0] evtEn_q;
  logic [31:0]      prdata_q;
  logic             pslverr_q;

  logic             wrEn;
  logic [5:0]       iUpperBorder;
  logic             sampleEnd;
  logic             timedOut;
  logic             hitIUpper;
  logic             hitILower;
  logic             hitQUpper;
  logic             hitQLower;
  logic             hit;
  logic [EVT_W-1:0] evtSet;
  logic [31:0]      rdMux;
  logic             rdErr;

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  // byte lane 0 carries all fields, so a write without it changes nothing
  assign wrEn = psel && penable && pwrite && pstrb[0];

  assign iUpperBorder = {qLowerReg_q[7:IUP_SLICE_POS], qUpperReg_q[7:IUP_SLICE_POS],
                         iLowerReg_q[7:IUP_SLICE_POS]};

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      qLowerReg_q <= BORDER_RST;
      qUpperReg_q <= BORDER_RST;
      iLowerReg_q <= BORDER_RST;
    end
    else if (wrEn)
    begin
      if (paddr == ADDR_Q_LOWER)
        qLowerReg_q <= pwdata[7:0];
      if (paddr == ADDR_Q_UPPER)
        qUpperReg_q <= pwdata[7:0];
      if (paddr == ADDR_I_LOWER)
        iLowerReg_q <= pwdata[7:0];
    end
  end

  // the older variant keeps the options location reserved: writes dropped
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      optDrive_q  <= 1'b0;
      optFilter_q <= 1'b0;
    end
    else if (NEWER_VARIANT && wrEn && paddr == ADDR_OPTIONS)
    begin
      optDrive_q  <= pwdata[OPT_DRIVE_POS];
      optFilter_q <= pwdata[OPT_FILT_POS];
    end
  end

  assign fullDriveSelect = optDrive_q;
  assign noiseFilterEnable = optFilter_q;

  // sequencer: a run samples until the front end ends it or the bound hits
  assign timedOut = (sampleCnt_q >= 9'(SAMPLE_LIMIT - 1));
  assign sampleEnd = (state_q == ST_SAMPLE) && (runDone || timedOut);
  assign sampleActive = (state_q == ST_SAMPLE);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
        if (runStart)
          state_d = ST_SAMPLE;
      ST_SAMPLE:
        if (sampleEnd)
          state_d = ST_EVAL;
      ST_EVAL:
        state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      sampleCnt_q <= 9'h000;
    else if (state_q == ST_SAMPLE)
      sampleCnt_q <= sampleCnt_q + 9'h001;
    else
      sampleCnt_q <= 9'h000;
  end

  // results and change flags are taken once, at the end of sampling
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      iResult_q <= RESULT_RST;
      qResult_q <= RESULT_RST;
      iChg_q    <= 1'b0;
      qChg_q    <= 1'b0;
    end
    else if (sampleEnd)
    begin
      iResult_q <= measI;
      qResult_q <= measQ;
      iChg_q    <= iChanging && optFilter_q;
      qChg_q    <= qChanging && optFilter_q;
    end
  end

  // a software set in the same cycle as a run start wins: it is the newer request
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      suppress_q <= 1'b0;
    else if (wrEn && paddr == ADDR_Q_RESULT)
      suppress_q <= pwdata[SUPPRESS_POS];
    else if (state_q == ST_IDLE && runStart)
      suppress_q <= 1'b0;
  end

  // decision uses only the captured results, one cycle after capture
  assign hitIUpper = iResult_q > iUpperBorder;
  assign hitQLower = qResult_q > qLowerReg_q[BORDER_W-1:0];
  assign hitQUpper = qResult_q > qUpperReg_q[BORDER_W-1:0];
  assign hitILower = iResult_q < iLowerReg_q[BORDER_W-1:0];
  assign hit = hitIUpper || hitQLower || hitQUpper || hitILower;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      detectReq_q <= 1'b0;
    else
      detectReq_q <= (state_q == ST_EVAL) && hit && !suppress_q;
  end

  assign detectInterruptFlag = detectReq_q;

  // event status: sticky, set wins over a clear in the same cycle
  always_comb
  begin
    evtSet = EVT_RST;
    evtSet[EVT_DETECT]   = detectReq_q;
    evtSet[EVT_RUN_DONE] = sampleEnd;
    evtSet[EVT_TIMEOUT]  = sampleEnd && !runDone;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      evtStat_q <= EVT_RST;
    else if (wrEn && paddr == ADDR_EVT_CLR)
      evtStat_q <= (evtStat_q & ~pwdata[EVT_W-1:0]) | evtSet;
    else
      evtStat_q <= evtStat_q | evtSet;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      evtEn_q <= EVT_RST;
    else if (wrEn && paddr == ADDR_EVT_EN)
      evtEn_q <= pwdata[EVT_W-1:0];
  end

  assign irq = |(evtStat_q & evtEn_q);

  always_comb
  begin
    rdMux = 32'h0000_0000;
    rdErr = 1'b0;
    unique case (paddr)
      ADDR_OPTIONS:
        if (NEWER_VARIANT)
          rdMux[3:0] = {optDrive_q, optFilter_q, qChg_q, iChg_q};
      ADDR_Q_LOWER:
        rdMux[7:0] = qLowerReg_q;
      ADDR_Q_UPPER:
        rdMux[7:0] = qUpperReg_q;
      ADDR_I_LOWER:
        rdMux[7:0] = iLowerReg_q;
      ADDR_I_RESULT:
        rdMux[5:0] = iResult_q;
      ADDR_Q_RESULT:
        rdMux[6:0] = {suppress_q, qResult_q};
      ADDR_EVT_STAT:
        rdMux[EVT_W-1:0] = evtStat_q;
      ADDR_EVT_EN:
        rdMux[EVT_W-1:0] = evtEn_q;
      ADDR_EVT_CLR:
        rdMux = 32'h0000_0000;
      default:
        rdErr = 1'b1;
    endcase
  end

  // read data and error are taken in the setup cycle and stand in the access cycle
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata_q  <= pwrite ? 32'h0000_0000 : rdMux;
      pslverr_q <= rdErr;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  border_assembly_a: assert property (
    (wrEn && paddr == ADDR_Q_LOWER) |=> (iUpperBorder[5:4] == $past(pwdata[7:6])))
    else $error("upper I border bits 5:4 not taken from q_lower_border");

  border_slices_a: assert property (
    (wrEn && paddr == ADDR_I_LOWER) ##1 !wrEn |=>
      (iUpperBorder[1:0] == $past(pwdata[7:6], 2)))
    else $error("upper I border bits 1:0 not taken from i_lower_border");

  upper_i_detect_a: assert property (
    (state_q == ST_EVAL && iResult_q > iUpperBorder && !suppress_q) |=> detectInterruptFlag)
    else $error("I above upper border gave no detect request");

  q_lower_detect_a: assert property (
    (state_q == ST_EVAL && qResult_q > qLowerReg_q[5:0] && !suppress_q)
      |=> detectInterruptFlag)
    else $error("Q above lower Q border gave no detect request");

  q_upper_detect_a: assert property (
    (state_q == ST_EVAL && qResult_q > qUpperReg_q[5:0] && !suppress_q)
      |=> detectInterruptFlag)
    else $error("Q above upper Q border gave no detect request");

  i_lower_detect_a: assert property (
    (state_q == ST_EVAL && iResult_q < iLowerReg_q[5:0] && !suppress_q)
      |=> detectInterruptFlag)
    else $error("I below lower I border gave no detect request");

  result_capture_a: assert property (
    (state_q == ST_SAMPLE && runDone) |=>
      (iResult_q == $past(measI) && qResult_q == $past(measQ)) ##1 (state_q == ST_IDLE))
    else $error("results not captured at end of run");

  result_read_a: assert property (
    (psel && !penable && !pwrite && paddr == ADDR_I_RESULT) |=>
      (prdata[31:6] == 26'h0 && prdata[5:0] == $past(iResult_q)))
    else $error("I result read wrong");

  q_result_read_a: assert property (
    (psel && !penable && !pwrite && paddr == ADDR_Q_RESULT) |=>
      (prdata[7] == 1'b0 && prdata[5:0] == $past(qResult_q)))
    else $error("Q result read wrong");

  suppress_block_a: assert property (
    suppress_q && !runStart |=> !detectInterruptFlag [*2])
    else $error("detect request while suppressed");

  older_variant_a: assert property (
    !NEWER_VARIANT |-> (!fullDriveSelect && !noiseFilterEnable && !iChg_q && !qChg_q))
    else $error("options active on older variant");

  drive_select_a: assert property (
    (NEWER_VARIANT && wrEn && paddr == ADDR_OPTIONS) |=>
      (fullDriveSelect == $past(pwdata[3])))
    else $error("drive select not taken from option bit 3");

  sample_bound_a: assert property (
    $rose(sampleActive) |-> ##[1:SmpBound] !sampleActive)
    else $error("sampling exceeded its bound");

  filter_gate_a: assert property (
    (sampleEnd && !optFilter_q) |=> (!qChg_q && !iChg_q))
    else $error("change flag set with filter off");

  i_change_flag_a: assert property (
    (sampleEnd && optFilter_q && iChanging) |=> iChg_q)
    else $error("I change flag not captured");

  detect_cov: cover property ((state_q == ST_EVAL && hit) ##1 detectInterruptFlag);
  suppress_cov: cover property (suppress_q && state_q == ST_EVAL && hit);
  timeout_cov: cover property (sampleEnd && !runDone);
  irq_cov: cover property ($rose(irq));

endmodule

`default_nettype wire
